// File: bench/alu_instruction_subset_bench.sv
// Self-checking bench for the instruction-subset datapath
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module alu_instruction_subset_bench;
  import alu_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, wake_req, osc_enable, exec_busy;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  initial forever #5 hclk = ~hclk;
  // Hang guard
  always @(posedge hclk) if (++cyc > 5000) begin n_mismatch++; close_out(); end
  alu_instruction_subset dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .wake_req, .osc_enable, .exec_busy);
  wake_src far (.hclk, .osc_enable, .wake_req);
  // One single-word transfer, waiting on hready in each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    `CK(n, e, q)
  endtask
  // Issue on file word 3, then wait for the end of execution
  task automatic ex(input op_e op, input logic dst, input logic [7:0] lit);
    bus(1, OFF_CMD, {8'h0, lit, 1'b0, 7'h03, 3'h0, dst, 1'b0, op});
    repeat (2) @(posedge hclk);
    while (exec_busy && osc_enable) @(posedge hclk);
  endtask
  task automatic arith();
    ex(literal_minus_acc_op, 0, 8'h03);
    chk("acc", OFF_ACC, 32'hFE);
    chk("flags", OFF_STATUS, 32'h18);
    bus(1, OFF_FDATA, 32'hFE);
    ex(reg_minus_acc_op, 1, 0);
    chk("file", OFF_FDATA, 0);
    chk("acc", OFF_ACC, 32'hFE);
    chk("flags", OFF_STATUS, 32'h1F);
  endtask
  task automatic logic_ops();
    ex(literal_xor_op, 0, 8'h0F);
    chk("acc", OFF_ACC, 32'hF1);
    chk("flags", OFF_STATUS, 32'h1B);
    bus(1, OFF_FDATA, 32'hF1);
    ex(reg_xor_op, 0, 0);
    chk("acc", OFF_ACC, 0);
    chk("file", OFF_FDATA, 32'hF1);
    chk("flags", OFF_STATUS, 32'h1F);
    bus(1, OFF_FDATA, 32'h3C);
    ex(nibble_exchange_op, 1, 0);
    chk("file", OFF_FDATA, 32'hC3);
    chk("flags", OFF_STATUS, 32'h1F);
  endtask
  // Return, nop and halt, with the watchdog counting beforehand
  task automatic ret_halt();
    bus(1, OFF_STACK, 32'h123);
    ex(op_return, 0, 0);
    chk("pc", OFF_PC, 32'h123);
    chk("flags", OFF_STATUS, 32'h1F);
    ex(op_nop, 0, 0);
    chk("pc", OFF_PC, 32'h124);
    repeat (600) @(posedge hclk);
    ex(op_halt, 0, 0);
    while (osc_enable) @(posedge hclk);
    chk("flags", OFF_STATUS, 32'h217);
    bus(0, OFF_WDT, 0);
    `CK("wdt", 1'b1, q[15:12] == 4'h0 && q[7:0] == 8'h00)
    while (!osc_enable) @(posedge hclk);
    chk("flags", OFF_STATUS, 32'h17);
    // Second halt: a command while halted is refused, a wake write ends it early
    ex(op_halt, 0, 0);
    while (osc_enable) @(posedge hclk);
    bus(1, OFF_CMD, 32'h00FF0305);
    bus(1, OFF_WAKE, 0);
    chk("flags", OFF_STATUS, 32'h17);
    chk("acc", OFF_ACC, 0);
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(1, OFF_CTRL, 1);
    bus(1, OFF_ACC, 5);
    bus(1, OFF_FADDR, 3);
    bus(1, OFF_FDATA, 3);
    arith();
    logic_ops();
    ret_halt();
    close_out();
  end
endmodule // alu_instruction_subset_bench
`default_nettype wire

// File: bench/alu_instruction_subset_sva.sv
// Port checker for the instruction-subset datapath
`timescale 1ns/10ps
`default_nettype none
module alu_instruction_subset_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        wake_req,
  input wire logic        osc_enable,
  input wire logic        exec_busy
);
  logic      cmd_ph;         // Data phase of an accepted command write
  wire [2:0] op = hwdata[2:0];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cmd_ph <= 1'b0;
    else cmd_ph <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00
                   && !exec_busy && osc_enable;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ret_busy_a: assert property (cmd_ph && op == 3'h1 |=> exec_busy [*5])
    else $error("return ended early");
  ret_end_a: assert property (cmd_ph && op == 3'h1 |-> ##[6:10] !exec_busy)
    else $error("return ran long");
  op_busy_a: assert property (cmd_ph && op != 3'h1 && op != 3'h2 |-> ##[2:6] !exec_busy)
    else $error("operation ran long");
  halt_osc_a: assert property (cmd_ph && op == 3'h2 |-> ##[2:6] !osc_enable)
    else $error("halt kept oscillator");
  wake_osc_a: assert property (wake_req && !osc_enable |-> ##[1:2] osc_enable)
    else $error("no wake");
  osc_cause_a: assert property ($fell(osc_enable) |-> $past(exec_busy))
    else $error("oscillator stopped unasked");
  busy_bound_a: assert property ($rose(exec_busy) |-> ##[1:10] (!exec_busy || !osc_enable))
    else $error("busy stuck");
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus stalled");
endmodule // alu_instruction_subset_sva
bind alu_instruction_subset alu_instruction_subset_sva chk (
  .hclk       (hclk),
  .hresetn    (hresetn),
  .hsel       (hsel),
  .haddr      (haddr),
  .htrans     (htrans),
  .hwrite     (hwrite),
  .hwdata     (hwdata),
  .hready     (hready),
  .hreadyout  (hreadyout),
  .hresp      (hresp),
  .wake_req   (wake_req),
  .osc_enable (osc_enable),
  .exec_busy  (exec_busy)
);
`default_nettype wire

// File: bench/wake_src.sv
// Far-side wake-up source that ends the halt state after a delay
`timescale 1ns/10ps
`default_nettype none
module wake_src (
  input  wire logic hclk,
  input  wire logic osc_enable,
  output var  logic wake_req
);
  int n = 0;  // Clocks spent halted
  always @(posedge hclk) begin
    n <= osc_enable ? 0 : n + 1;
    wake_req <= (n == 30);
  end
endmodule // wake_src
`default_nettype wire

// File: pkg/alu_pkg.sv
// Shared constants, types and register map of the instruction-subset datapath
package alu_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int DATA_W       = 8;    // Data word width
  localparam int FILE_ADDR_W  = 7;    // Register file address width
  localparam int FILE_DEPTH   = 128;  // Register file words
  localparam int PC_WIDTH     = 13;   // Program counter width
  localparam int STACK_SLOTS  = 8;    // Return stack depth
  localparam int WDT_WIDTH    = 8;    // Watchdog counter width
  localparam int PRESC_WIDTH  = 8;    // Watchdog prescaler width
  localparam int BUS_W        = 32;   // Bus data width
  localparam int OFF_W        = 8;    // Decoded address bits

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;  // hclk period
  localparam int CYCLE_CLOCKS   = 4;   // Oscillator clocks per instruction cycle
  localparam int PHASE_W        = 2;   // Width of the phase counter
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CYCLE_CLOCKS - 1);
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 2'h0;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [OFF_W-1:0] OFF_CMD    = 8'h00;  // Instruction issue
  localparam logic [OFF_W-1:0] OFF_STATUS = 8'h04;  // Flags and state
  localparam logic [OFF_W-1:0] OFF_ACC    = 8'h08;  // Accumulator
  localparam logic [OFF_W-1:0] OFF_PC     = 8'h0C;  // Program counter
  localparam logic [OFF_W-1:0] OFF_STACK  = 8'h10;  // Stack push / top
  localparam logic [OFF_W-1:0] OFF_WDT    = 8'h14;  // Watchdog view
  localparam logic [OFF_W-1:0] OFF_FADDR  = 8'h18;  // File window address
  localparam logic [OFF_W-1:0] OFF_FDATA  = 8'h1C;  // File window data
  localparam logic [OFF_W-1:0] OFF_CTRL   = 8'h20;  // Watchdog enable
  localparam logic [OFF_W-1:0] OFF_WAKE   = 8'h24;  // Wake from halt

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMD_OP_LSB    = 0;   // Operation code
  localparam int CMD_OP_W      = 3;
  localparam int CMD_DEST_BIT  = 4;   // Destination select
  localparam int CMD_ADDR_LSB  = 8;   // Register file address
  localparam int CMD_LIT_LSB   = 16;  // Literal
  localparam int ST_BUSY_BIT   = 8;   // Status: executing
  localparam int ST_HALT_BIT   = 9;   // Status: halted
  localparam int STK_PTR_LSB   = 16;  // Stack view: pointer
  localparam int WDT_PRE_LSB   = 8;   // Watchdog view: prescaler
  localparam int CTRL_WDT_BIT  = 0;   // Control: watchdog run
  localparam logic DEST_ACC    = 1'b0;
  localparam logic DEST_REG    = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [CMD_OP_W-1:0] {
    op_nop, op_return, op_halt, literal_minus_acc_op,
    reg_minus_acc_op, literal_xor_op, reg_xor_op, nibble_exchange_op
  } op_e;

  typedef enum {st_idle, st_wait, st_return2, st_halted} exec_state_e;

  typedef struct packed {
    op_e                    op;
    logic                   dest;
    logic [FILE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      lit;
  } cmd_s;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } flags_s;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [OFF_W-1:0] addr;
  } ahb_cap_s;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam flags_s FLAGS_RST = '{watchdog_expiry_flag: 1'b1, power_down_flag: 1'b1,
                                   zero: 1'b0, half_carry_flag: 1'b0, carry: 1'b0};
  localparam cmd_s   CMD_RST   = '{op: op_nop, dest: 1'b0, addr: 7'h00, lit: 8'h00};

endpackage

// File: src/alu_instruction_subset.sv
// Instruction-subset execution datapath with an AHB-Lite register slave
// Summary of operation
// - Return pops stack into PC, flags kept
// - Return takes two instruction cycles
// - Halt clears power-down, sets expiry flag
// - Halt clears watchdog counter and prescaler
// - Halt stops oscillator until wake-up
// - Literal minus accumulator into accumulator, C/DC/Z
// - Register minus accumulator, C/DC/Z updated
// - Destination bit: 0 accumulator, 1 register
// - Literal xor into accumulator, Z only
// - Register xor to destination, Z only
// - Nibble exchange, no flag changes
// - Zero flag shows 8-bit result zero
`timescale 1ns/10ps
`default_nettype none
module alu_instruction_subset #(
  parameter int PC_W    = alu_pkg::PC_WIDTH,     // Program counter width
  parameter int DEPTH   = alu_pkg::STACK_SLOTS,  // Return stack slots
  parameter int WDT_W   = alu_pkg::WDT_WIDTH,    // Watchdog counter width
  parameter int PRESC_W = alu_pkg::PRESC_WIDTH   // Watchdog prescaler width
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [alu_pkg::BUS_W-1:0]   haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [alu_pkg::BUS_W-1:0]   hwdata,
  input  wire logic                        hready,
  output logic      [alu_pkg::BUS_W-1:0]   hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        wake_req,
  output logic                             osc_enable,
  output logic                             exec_busy
);
  import alu_pkg::*;

  localparam int SP_W = $clog2(DEPTH);  // Stack pointer width

  // ****************************************************************
  // State declarations
  // ****************************************************************
  ahb_cap_s               cap;                  // Captured address phase
  exec_state_e            state;                // Execution state
  exec_state_e            next_state;           // Next execution state
  cmd_s                   cmd;                  // Instruction being executed
  flags_s                 flags;                // Status flags
  flags_s                 next_flags;           // Next status flags
  logic [DATA_W-1:0]      acc;                  // Working accumulator
  logic [DATA_W-1:0]      next_acc;             // Next accumulator
  logic [PC_W-1:0]        pc;                   // Program counter
  logic [PC_W-1:0]        next_pc;              // Next program counter
  logic [PC_W-1:0]        stack [DEPTH];        // Return stack slots
  logic [SP_W-1:0]        sp;                   // Next free stack slot
  logic [DATA_W-1:0]      file_mem [FILE_DEPTH]; // Data register file
  logic [FILE_ADDR_W-1:0] file_addr;            // Bus window address
  logic [PHASE_W-1:0]     phase;                // Clock within instruction cycle
  logic [WDT_W-1:0]       watchdog_counter;     // Watchdog count
  logic [PRESC_W-1:0]     presc;                // Watchdog prescaler
  logic                   wdt_run;              // Watchdog enabled by software

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Write strobe for one offset, valid in the data phase
  function automatic logic wr_hit(input ahb_cap_s c, input logic [OFF_W-1:0] off);
    return c.valid & c.write & (c.addr == off);
  endfunction

  // Address phase accepted; hsize is ignored since only words are used
  wire logic             addr_take = hsel & hready & htrans[1];
  wire logic [OFF_W-1:0] req_off   = haddr[OFF_W-1:0];
  wire logic             wr_cmd    = wr_hit(cap, OFF_CMD);
  wire logic             wr_acc    = wr_hit(cap, OFF_ACC);
  wire logic             wr_pc     = wr_hit(cap, OFF_PC);
  wire logic             wr_push   = wr_hit(cap, OFF_STACK);
  wire logic             wr_faddr  = wr_hit(cap, OFF_FADDR);
  wire logic             wr_fdata  = wr_hit(cap, OFF_FDATA);
  wire logic             wr_ctrl   = wr_hit(cap, OFF_CTRL);
  wire logic             wr_wake   = wr_hit(cap, OFF_WAKE);

  // Instruction word fields from the write data
  wire cmd_s bus_cmd = '{op:   op_e'(hwdata[CMD_OP_LSB +: CMD_OP_W]),
                         dest: hwdata[CMD_DEST_BIT],
                         addr: hwdata[CMD_ADDR_LSB +: FILE_ADDR_W],
                         lit:  hwdata[CMD_LIT_LSB +: DATA_W]};

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  // one tick per four clocks
  wire logic halted = (state == st_halted);
  wire logic tick   = (phase == PHASE_LAST) & ~halted;

  // Phase counter freezes while the oscillator is stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PHASE_ZERO;
    end else if (!halted) begin
      phase <= (phase == PHASE_LAST) ? PHASE_ZERO : phase + PHASE_W'(1);
    end
  end

  // ****************************************************************
  // Datapath
  // ****************************************************************
  wire logic              is_literal = (cmd.op == literal_minus_acc_op) |
                                       (cmd.op == literal_xor_op);
  wire logic [DATA_W-1:0] operand    = is_literal ? cmd.lit : file_mem[cmd.addr];
  wire logic              execute    = (state == st_wait) & tick;
  wire logic              do_return  = execute & (cmd.op == op_return);
  wire logic              do_halt    = execute & (cmd.op == op_halt);
  wire logic [SP_W-1:0]   sp_top     = sp - SP_W'(1);
  logic [DATA_W-1:0]      result;
  logic                   res_c;
  logic                   res_dc;
  logic                   res_z;
  logic                   upd_arith;
  logic                   upd_zero;
  logic                   to_acc;
  logic                   to_reg;

  // Result and flag computation
  alu_result_unit u_result (
    .op           (cmd.op),
    .acc          (acc),
    .operand      (operand),
    .dest         (cmd.dest),
    .result       (result),
    .carry        (res_c),
    .half_carry   (res_dc),
    .zero         (res_z),
    .update_arith (upd_arith),
    .update_zero  (upd_zero),
    .write_acc    (to_acc),
    .write_reg    (to_reg)
  );

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Prescaler and counter run on hclk so they keep counting in halt
  wire logic presc_full = (presc == {PRESC_W{1'b1}});
  wire logic wdt_full   = (watchdog_counter == {WDT_W{1'b1}});
  wire logic wdt_over   = wdt_run & presc_full & wdt_full & ~do_halt;

  // Counter and prescaler; the halt clear wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc            <= '0;
      watchdog_counter <= '0;
    end else if (do_halt) begin
      presc            <= '0;
      watchdog_counter <= '0;
    end else if (wdt_run) begin
      presc <= presc + PRESC_W'(1);
      if (presc_full) begin
        watchdog_counter <= watchdog_counter + WDT_W'(1);
      end
    end
  end

  // Watchdog run bit written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_run <= 1'b0;
    end else if (wr_ctrl) begin
      wdt_run <= hwdata[CTRL_WDT_BIT];
    end
  end

  // ****************************************************************
  // Execution sequencer
  // ****************************************************************
  // Next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      // New instructions are taken only when idle
      st_idle: begin
        if (wr_cmd) begin
          next_state = st_wait;
        end
      end
      // Wait for the next instruction-cycle boundary
      st_wait: begin
        if (tick) begin
          if (cmd.op == op_return) begin
            next_state = st_return2;
          end else if (cmd.op == op_halt) begin
            next_state = st_halted;
          end else begin
            next_state = st_idle;
          end
        end
      end
      // Second instruction cycle of a return
      st_return2: begin
        if (tick) begin
          next_state = st_idle;
        end
      end
      st_halted: begin
        if (wake_req | wr_wake | wdt_over) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // State register and registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= st_idle;
      osc_enable <= 1'b1;
      exec_busy  <= 1'b0;
    end else begin
      state      <= next_state;
      osc_enable <= (next_state != st_halted);
      exec_busy  <= (next_state == st_wait) | (next_state == st_return2);
    end
  end

  // Latch the instruction when it is accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= CMD_RST;
    end else if (wr_cmd & (state == st_idle)) begin
      cmd <= bus_cmd;
    end
  end

  // ****************************************************************
  // Program counter and return stack
  // ****************************************************************
  // top entry loads the PC
  always_comb begin
    next_pc = pc;
    if (do_return) begin
      next_pc = stack[sp_top];
    end else if (execute) begin
      next_pc = pc + PC_W'(1);
    end else if (wr_pc) begin
      next_pc = hwdata[PC_W-1:0];
    end
  end

  // Program counter register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= '0;
    end else begin
      pc <= next_pc;
    end
  end

  // Stack pointer: pop on return, push by software; wraps like a ring
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp <= '0;
    end else if (do_return) begin
      sp <= sp_top;
    end else if (wr_push) begin
      sp <= sp + SP_W'(1);
    end
  end

  // Stack slots hold no reset, like a memory
  always_ff @(posedge hclk) begin
    if (wr_push & ~do_return) begin
      stack[sp] <= hwdata[PC_W-1:0];
    end
  end

  // ****************************************************************
  // Accumulator, register file and flags
  // ****************************************************************
  // Execution has priority over a software write of the accumulator
  always_comb begin
    next_acc = acc;
    if (execute & to_acc) begin
      next_acc = result;
    end else if (wr_acc) begin
      next_acc = hwdata[DATA_W-1:0];
    end
  end

  // Accumulator register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // Register file: write-back of a result beats a bus write
  always_ff @(posedge hclk) begin
    if (execute & to_reg) begin
      file_mem[cmd.addr] <= result;
    end else if (wr_fdata) begin
      file_mem[file_addr] <= hwdata[DATA_W-1:0];
    end
  end

  // Register file window address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      file_addr <= '0;
    end else if (wr_faddr) begin
      file_addr <= hwdata[FILE_ADDR_W-1:0];
    end
  end

  // Flag updates; a return leaves every flag alone
  always_comb begin
    next_flags = flags;
    if (execute & upd_arith) begin
      next_flags.carry           = res_c;
      next_flags.half_carry_flag = res_dc;
    end
    if (execute & upd_zero) begin
      next_flags.zero = res_z;
    end
    if (do_halt) begin
      next_flags.power_down_flag      = 1'b0;
      next_flags.watchdog_expiry_flag = 1'b1;
    end else if (wdt_over) begin
      next_flags.watchdog_expiry_flag = 1'b0;
    end
  end

  // Flag register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************************************
  // Read data and bus response
  // ****************************************************************
  wire logic [BUS_W-1:0] status_word = BUS_W'(flags) |
                                       (BUS_W'(exec_busy) << ST_BUSY_BIT) |
                                       (BUS_W'(halted) << ST_HALT_BIT);
  wire logic [BUS_W-1:0] stack_word  = BUS_W'(stack[sp_top]) |
                                       (BUS_W'(sp) << STK_PTR_LSB);
  wire logic [BUS_W-1:0] wdt_word    = BUS_W'(watchdog_counter) |
                                       (BUS_W'(presc) << WDT_PRE_LSB);
  logic      [BUS_W-1:0] rd_word;

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    case (req_off)
      OFF_CMD:    rd_word = BUS_W'(cmd);
      OFF_STATUS: rd_word = status_word;
      OFF_ACC:    rd_word = BUS_W'(acc);
      OFF_PC:     rd_word = BUS_W'(pc);
      OFF_STACK:  rd_word = stack_word;
      OFF_WDT:    rd_word = wdt_word;
      OFF_FADDR:  rd_word = BUS_W'(file_addr);
      OFF_FDATA:  rd_word = BUS_W'(file_mem[file_addr]);
      OFF_CTRL:   rd_word = BUS_W'(wdt_run);
      default:    rd_word = '0;
    endcase
  end

  // Capture the address phase; read data is registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap       <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      // Zero-wait slave, always OKAY
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        cap <= '{valid: addr_take, write: hwrite, addr: req_off};
      end
      if (addr_take & ~hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

endmodule // alu_instruction_subset
`default_nettype wire

// File: src/alu_result_unit.sv
// Combinational result and flag unit for the subtract, exclusive-OR and swap operations
`timescale 1ns/10ps
`default_nettype none
module alu_result_unit (
  input  wire alu_pkg::op_e              op,
  input  wire logic [alu_pkg::DATA_W-1:0] acc,
  input  wire logic [alu_pkg::DATA_W-1:0] operand,
  input  wire logic                       dest,
  output logic      [alu_pkg::DATA_W-1:0] result,
  output logic                            carry,
  output logic                            half_carry,
  output logic                            zero,
  output logic                            update_arith,
  output logic                            update_zero,
  output logic                            write_acc,
  output logic                            write_reg
);
  import alu_pkg::*;

  // ****************************************************************
  // Subtraction as operand plus inverted accumulator plus one
  // ****************************************************************
  wire logic [DATA_W:0] diff     = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
  wire logic [4:0]      low_diff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire logic            use_dest = (dest == DEST_REG);

  // Select result, flag updates and destination
  always_comb begin
    result       = operand;
    update_arith = 1'b0;
    update_zero  = 1'b0;
    write_acc    = 1'b0;
    write_reg    = 1'b0;
    case (op)
      literal_minus_acc_op: begin
        result       = diff[DATA_W-1:0];
        update_arith = 1'b1;
        update_zero  = 1'b1;
        write_acc    = 1'b1;
      end
      reg_minus_acc_op: begin
        result       = diff[DATA_W-1:0];
        update_arith = 1'b1;
        update_zero  = 1'b1;
        write_acc    = ~use_dest;
        write_reg    = use_dest;
      end
      literal_xor_op: begin
        result      = acc ^ operand;
        update_zero = 1'b1;
        write_acc   = 1'b1;
      end
      reg_xor_op: begin
        result      = acc ^ operand;
        update_zero = 1'b1;
        write_acc   = ~use_dest;
        write_reg   = use_dest;
      end
      nibble_exchange_op: begin
        result    = {operand[3:0], operand[7:4]};
        write_acc = ~use_dest;
        write_reg = use_dest;
      end
      // No datapath result for other operations
      default: begin
        result = operand;
      end
    endcase
  end

  assign carry      = diff[DATA_W];
  assign half_carry = low_diff[4];
  assign zero       = (result == 8'h00);

endmodule // alu_result_unit
`default_nettype wire
